/* File: core/mmad_decode.sv */
// monitor memory map, slave address decode, write protect and resistor look-up
// Notes on behaviour
// - supply reading is unsigned 16-bit, 100uV LSB
// - monitor readings unsigned 16-bit, 38.147uV LSB
// - temperature is two's complement, 1/256 degree
// - temperature maps to 80h..C7h, clamped ends
// - each entry gives both resistors 8-bit positions
// - index disabled: positions from bytes 82h, 83h
// - answer A0h and A2h, or main only
// - main address from byte 8Ch when selected
// - 80h and up banked, selected by 7Fh
// - aux address cannot reach tables; aux is table
// - dual select set: table zero, aux silent
// - main protected only when pin and enable
// - aux enable alone protects aux and table zero
// - stored main address defaults to A2h
// - 16-bit left-justified, low variant masks three bits
// - five quantities refreshed in round-robin order
// - protect pin reads high unless grounded
`timescale 1ns/10ps
`default_nettype none
module mmad_decode
   import mmad_pkg::*;
#(
   parameter bit LOW_RES_VARIANT = 1'b0
) (
   // clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       sys_rst_in,
   // byte access port from the 2-wire controller
   input  wire logic       req_valid_in,
   input  wire mmad_req_s  req_in,
   output logic            ack_out,
   output logic            rsp_valid_out,
   output logic [7:0]      rdata_out,
   // conversion results
   input  wire logic       conv_done_in,
   input  wire logic [15:0] conv_value_in,
   // write protect pin
   input  wire logic       write_protect_pin_in,
   // resistor positions
   output logic [7:0]      res0_pos_out,
   output logic [7:0]      res1_pos_out
);
   // ==========================================================================
   // storage
   logic [7:0]  aux_mem   [128];  // auxiliary memory, also table zero
   logic [7:0]  main_mem  [128];  // main memory below 80h
   logic [7:0]  ctrl_mem  [128];  // table one general bytes
   logic [7:0]  lut0_mem  [128];  // resistor 0 look-up entries
   logic [7:0]  lut1_mem  [128];  // resistor 1 look-up entries
   logic [15:0] meas_reg  [MMAD_CH_COUNT];
   logic [7:0]  cfg_reg;
   logic [7:0]  table_sel_reg;
   logic [7:0]  manual0_reg;
   logic [7:0]  manual1_reg;
   logic [7:0]  main_addr_reg;
   logic [2:0]  rr_ptr_reg;
   logic [2:0]  wp_sync_reg;
   logic        wp_level_reg;
   // ==========================================================================
   // decode signals
   logic        cfg_ten, cfg_das, cfg_afm, cfg_mpe, cfg_ape;
   logic [7:0]  main_dev_addr;
   logic        aux_hit, main_hit, acc, wr, in_bank, ro_area;
   logic        main_prot, aux_prot;
   logic        aux_we, main_we, tsel_we, ctrl_we, lut0_we, lut1_we;
   logic [6:0]  a;
   logic [7:0]  rd_byte;
   logic [15:0] meas_new;
   logic        temp_done;
   logic signed [8:0] temp_whole, temp_ofs;
   logic [6:0]  lut_idx_new;
   logic [7:0]  lut0_sel, lut1_sel;
   logic [3:0]  meas_ofs;

   assign cfg_ten = cfg_reg[MMAD_CFG_TEN_BIT];
   assign cfg_das = cfg_reg[MMAD_CFG_DAS_BIT];
   assign cfg_afm = cfg_reg[MMAD_CFG_AFM_BIT];
   assign cfg_mpe = cfg_reg[MMAD_CFG_MPE_BIT];
   assign cfg_ape = cfg_reg[MMAD_CFG_APE_BIT];
   assign a       = req_in.mem_addr[6:0];
   assign in_bank = req_in.mem_addr[MMAD_BANK_BIT];
   assign wr      = req_in.write;

   // ==========================================================================
   // slave address match
   assign main_dev_addr = cfg_afm ? main_addr_reg : MMAD_MAIN_DEV_DFLT;
   assign main_hit = req_in.dev_addr[7:1] == main_dev_addr[7:1];
   assign aux_hit  = !cfg_das && !main_hit
                     && req_in.dev_addr[7:1] == MMAD_AUX_DEV_ADDR[7:1];
   assign acc      = req_valid_in && (aux_hit || main_hit);
   assign ack_out  = acc;

   // ==========================================================================
   // write protection and write enables
   assign main_prot = wp_level_reg && cfg_mpe;
   assign aux_prot  = cfg_ape;
   assign ro_area   = req_in.mem_addr >= MMAD_MEAS_BASE
                      && req_in.mem_addr <= MMAD_RO_LAST;
   // aux space above 7Fh does not exist from the aux address
   assign aux_we  = acc && wr && !aux_prot
                    && ((aux_hit && !in_bank)
                        || (main_hit && in_bank && table_sel_reg == MMAD_TBL_AUX));
   assign main_we = acc && wr && main_hit && !in_bank && !main_prot && !ro_area;
   assign tsel_we = main_we && req_in.mem_addr == MMAD_TABLE_SEL_OFF;
   assign ctrl_we = acc && wr && main_hit && in_bank && !main_prot
                    && table_sel_reg == MMAD_TBL_CTRL;
   assign lut0_we = acc && wr && main_hit && in_bank && !main_prot
                    && table_sel_reg == MMAD_TBL_LUT0;
   assign lut1_we = acc && wr && main_hit && in_bank && !main_prot
                    && table_sel_reg == MMAD_TBL_LUT1;

   // ==========================================================================
   // write protect pin: three stages, level moves when stages two and three agree
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         wp_sync_reg  <= MMAD_WP_SYNC_RST;
         wp_level_reg <= 1'b1;
      end else begin
         wp_sync_reg <= {wp_sync_reg[1:0], write_protect_pin_in};
         if (wp_sync_reg[1] == wp_sync_reg[2]) begin
            wp_level_reg <= wp_sync_reg[2];
         end
      end
   end

   // nonvolatile arrays, not cleared by reset
   always_ff @(posedge core_clk_in) begin
      if (aux_we) begin
         aux_mem[a] <= req_in.wdata;
      end
      if (main_we && !tsel_we) begin
         main_mem[a] <= req_in.wdata;
      end
      if (ctrl_we) begin
         ctrl_mem[a] <= req_in.wdata;
      end
      if (lut0_we) begin
         lut0_mem[a] <= req_in.wdata;
      end
      if (lut1_we) begin
         lut1_mem[a] <= req_in.wdata;
      end
   end

   // table select byte
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         table_sel_reg <= MMAD_TABLE_SEL_RST;
      end else if (tsel_we) begin
         table_sel_reg <= req_in.wdata;
      end
   end

   // control bytes held in table one
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         cfg_reg       <= MMAD_CFG_RST;
         manual0_reg   <= MMAD_MANUAL_RST;
         manual1_reg   <= MMAD_MANUAL_RST;
         main_addr_reg <= MMAD_MAIN_DEV_DFLT;
      end else if (ctrl_we) begin
         case (req_in.mem_addr)
            MMAD_CFG_OFF:       cfg_reg       <= req_in.wdata;
            MMAD_MANUAL0_OFF:   manual0_reg   <= req_in.wdata;
            MMAD_MANUAL1_OFF:   manual1_reg   <= req_in.wdata;
            MMAD_MAIN_ADDR_OFF: main_addr_reg <= req_in.wdata;
            default: ;
         endcase
      end
   end

   // ==========================================================================
   // measurement capture in round-robin order
   assign meas_new  = conv_value_in
                      & (LOW_RES_VARIANT ? MMAD_MASK_LOWRES : MMAD_MASK_FULL);
   assign temp_done = conv_done_in && rr_ptr_reg == MMAD_CH_TEMP;

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         rr_ptr_reg <= MMAD_CH_TEMP;
      end else if (conv_done_in) begin
         rr_ptr_reg <= (rr_ptr_reg == MMAD_CH_LAST) ? MMAD_CH_TEMP
                                                    : rr_ptr_reg + 3'h1;
      end
   end

   // one 16-bit slot per channel
   generate
      for (genvar ch = 0; ch < MMAD_CH_COUNT; ch++) begin : g_meas
         always_ff @(posedge core_clk_in) begin
            if (sys_rst_in) begin
               meas_reg[ch] <= MMAD_MEAS_RST;
            end else if (conv_done_in && rr_ptr_reg == 3'(ch)) begin
               meas_reg[ch] <= meas_new;
            end
         end
      end
   endgenerate

   // ==========================================================================
   // temperature to look-up index, clamped at both ends
   assign temp_whole = {meas_new[15], meas_new[15:8]};
   assign temp_ofs   = temp_whole - MMAD_LUT_TEMP_MIN;
   always_comb begin
      if (temp_whole < MMAD_LUT_TEMP_MIN) begin
         lut_idx_new = MMAD_LUT_IDX_MIN;
      end else if (temp_whole > MMAD_LUT_TEMP_MAX) begin
         lut_idx_new = MMAD_LUT_IDX_MAX;
      end else begin
         lut_idx_new = temp_ofs[7:1];
      end
   end
   assign lut0_sel = lut0_mem[lut_idx_new];
   assign lut1_sel = lut1_mem[lut_idx_new];

   // resistor positions
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         res0_pos_out <= MMAD_MANUAL_RST;
         res1_pos_out <= MMAD_MANUAL_RST;
      end else if (!cfg_ten) begin
         res0_pos_out <= manual0_reg;
         res1_pos_out <= manual1_reg;
      end else if (temp_done) begin
         res0_pos_out <= lut0_sel;
         res1_pos_out <= lut1_sel;
      end
   end

   // ==========================================================================
   // read multiplexer
   assign meas_ofs = 4'(req_in.mem_addr - MMAD_MEAS_BASE);
   always_comb begin
      rd_byte = MMAD_RD_IDLE;
      if (aux_hit) begin
         rd_byte = in_bank ? MMAD_RD_IDLE : aux_mem[a];
      end else if (!in_bank) begin
         if (req_in.mem_addr == MMAD_TABLE_SEL_OFF) begin
            rd_byte = table_sel_reg;
         end else if (ro_area) begin
            if (req_in.mem_addr <= MMAD_MEAS_LAST) begin
               rd_byte = meas_ofs[0] ? meas_reg[meas_ofs[3:1]][7:0]
                                     : meas_reg[meas_ofs[3:1]][15:8];
            end
         end else begin
            rd_byte = main_mem[a];
         end
      end else begin
         case (table_sel_reg)
            MMAD_TBL_AUX:  rd_byte = aux_mem[a];
            MMAD_TBL_CTRL: begin
               case (req_in.mem_addr)
                  MMAD_CFG_OFF:       rd_byte = cfg_reg;
                  MMAD_MANUAL0_OFF:   rd_byte = manual0_reg;
                  MMAD_MANUAL1_OFF:   rd_byte = manual1_reg;
                  MMAD_MAIN_ADDR_OFF: rd_byte = main_addr_reg;
                  default:            rd_byte = ctrl_mem[a];
               endcase
            end
            MMAD_TBL_LUT0: rd_byte = lut0_mem[a];
            MMAD_TBL_LUT1: rd_byte = lut1_mem[a];
            default:       rd_byte = MMAD_RD_IDLE;
         endcase
      end
   end

   // answer one cycle after an accepted request
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         rsp_valid_out <= 1'b0;
         rdata_out     <= MMAD_RD_IDLE;
      end else begin
         rsp_valid_out <= acc;
         if (acc && !wr) begin
            rdata_out <= rd_byte;
         end
      end
   end

   // ==========================================================================
   // checks
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);

   AST_NO_FOREIGN_ACK: assert property (
      req_valid_in && req_in.dev_addr[7:1] != main_dev_addr[7:1]
      && (cfg_das || req_in.dev_addr[7:1] != MMAD_AUX_DEV_ADDR[7:1]) |-> !ack_out)
      else $error("ack given for an address not configured");
   AST_AUX_SILENT: assert property (
      cfg_das |-> !aux_hit)
      else $error("aux address answered with dual select set");
   AST_FIXED_MAIN: assert property (
      !cfg_afm |-> main_dev_addr == MMAD_MAIN_DEV_DFLT)
      else $error("main address not default while memory address off");
   AST_MAIN_PROTECT: assert property (
      wp_level_reg && cfg_mpe |-> !main_we && !ctrl_we && !lut0_we && !lut1_we)
      else $error("main memory written while protected");
   AST_AUX_PROTECT: assert property (
      cfg_ape |-> !aux_we)
      else $error("aux memory written while protected");
   AST_MANUAL_MODE: assert property (
      !cfg_ten && $past(!cfg_ten) |-> res0_pos_out == $past(manual0_reg)
      && res1_pos_out == $past(manual1_reg))
      else $error("manual position not followed");
   AST_LUT_RANGE: assert property (
      lut_idx_new <= MMAD_LUT_IDX_MAX)
      else $error("look-up index out of range");
   AST_LUT_UPDATE: assert property (
      cfg_ten && temp_done |=> res0_pos_out == $past(lut0_sel)
      && res1_pos_out == $past(lut1_sel))
      else $error("positions not loaded from look-up entry");
   AST_ROUND_ROBIN: assert property (
      conv_done_in && rr_ptr_reg == MMAD_CH_LAST |=> rr_ptr_reg == MMAD_CH_TEMP)
      else $error("channel sequence did not wrap");
   AST_LOWRES_MASK: assert property (
      conv_done_in |=> meas_reg[$past(rr_ptr_reg)][2:0]
      == (LOW_RES_VARIANT ? 3'h0 : $past(conv_value_in[2:0])))
      else $error("low bits not handled for this variant");
   AST_ANSWER: assert property (
      acc |=> rsp_valid_out ##1 !rsp_valid_out || $past(acc))
      else $error("answer pulse missing");

   COV_LUT_LOAD:   cover property (cfg_ten && temp_done ##1 res0_pos_out != $past(res0_pos_out));
   COV_WR_REFUSED: cover property (acc && wr && main_prot && !in_bank);
   COV_TABLE0_RD:  cover property (acc && !wr && main_hit && in_bank
                                   && table_sel_reg == MMAD_TBL_AUX);
   COV_CLAMP_HIGH: cover property (temp_done && temp_whole > MMAD_LUT_TEMP_MAX);
endmodule : mmad_decode
`default_nettype wire

/* File: core/mmad_pkg.sv */
// constants and carrier types for the monitor memory address decode block
package mmad_pkg;
   // ==========================================================================
   // slave addresses and reset values
   localparam logic [7:0] MMAD_AUX_DEV_ADDR   = 8'hA0;
   localparam logic [7:0] MMAD_MAIN_DEV_DFLT  = 8'hA2;
   localparam logic [7:0] MMAD_CFG_RST        = 8'h00;
   localparam logic [7:0] MMAD_TABLE_SEL_RST  = 8'h00;
   localparam logic [7:0] MMAD_MANUAL_RST     = 8'h00;
   localparam logic [7:0] MMAD_RD_IDLE        = 8'h00;
   localparam logic [15:0] MMAD_MEAS_RST      = 16'h0000;
   localparam logic [2:0]  MMAD_WP_SYNC_RST   = 3'h7;
   // ==========================================================================
   // byte offsets
   localparam logic [7:0] MMAD_MEAS_BASE      = 8'h60;
   localparam logic [7:0] MMAD_MEAS_LAST      = 8'h69;
   localparam logic [7:0] MMAD_RO_LAST        = 8'h6F;
   localparam logic [7:0] MMAD_TABLE_SEL_OFF  = 8'h7F;
   localparam logic [7:0] MMAD_CFG_OFF        = 8'h80;
   localparam logic [7:0] MMAD_MANUAL0_OFF    = 8'h82;
   localparam logic [7:0] MMAD_MANUAL1_OFF    = 8'h83;
   localparam logic [7:0] MMAD_MAIN_ADDR_OFF  = 8'h8C;
   localparam int         MMAD_BANK_BIT       = 7;
   // ==========================================================================
   // table numbers written to the table select byte
   localparam logic [7:0] MMAD_TBL_AUX        = 8'h00;
   localparam logic [7:0] MMAD_TBL_CTRL       = 8'h01;
   localparam logic [7:0] MMAD_TBL_LUT0       = 8'h02;
   localparam logic [7:0] MMAD_TBL_LUT1       = 8'h03;
   // ==========================================================================
   // configuration byte fields
   localparam int         MMAD_CFG_TEN_BIT    = 0;
   localparam int         MMAD_CFG_DAS_BIT    = 1;
   localparam int         MMAD_CFG_AFM_BIT    = 2;
   localparam int         MMAD_CFG_MPE_BIT    = 3;
   localparam int         MMAD_CFG_APE_BIT    = 4;
   // ==========================================================================
   // temperature look-up and measurement format
   localparam logic signed [8:0] MMAD_LUT_TEMP_MIN = -9'sd40;
   localparam logic signed [8:0] MMAD_LUT_TEMP_MAX = 9'sd102;
   localparam logic [6:0]  MMAD_LUT_IDX_MIN   = 7'h00;
   localparam logic [6:0]  MMAD_LUT_IDX_MAX   = 7'h47;
   localparam logic [15:0] MMAD_MASK_LOWRES   = 16'hFFF8;
   localparam logic [15:0] MMAD_MASK_FULL     = 16'hFFFF;
   localparam logic [2:0]  MMAD_CH_TEMP       = 3'h0;
   localparam logic [2:0]  MMAD_CH_LAST       = 3'h4;
   localparam int          MMAD_CH_COUNT      = 5;
   // ==========================================================================
   // byte access request from the 2-wire controller
   typedef struct packed {
      logic [7:0] dev_addr;  // slave address byte, bit 0 ignored
      logic [7:0] mem_addr;  // byte offset
      logic       write;     // 1 write, 0 read
      logic [7:0] wdata;     // write data
   } mmad_req_s;
endpackage : mmad_pkg

/* File: verif/mmad_host.sv */
// host-side model that issues byte requests to the decode block
`timescale 1ns/10ps
`default_nettype none
module mmad_host
   import mmad_pkg::*;
(
   // clock
   input  wire logic       clk_in,
   // request side
   output logic            req_valid_out,
   output var mmad_req_s   req_out,
   // answer side
   input  wire logic       ack_in,
   input  wire logic       rsp_valid_in,
   input  wire logic [7:0] rdata_in
);
   // ==========================================================================
   // idle request lines
   initial begin
      req_valid_out = 1'b0;
      req_out       = '0;
   end
   // one byte transfer; a missing answer after an accept turns ok unknown
   task automatic xfer(input logic [7:0] dev, adr, input logic is_wr,
                       input logic [7:0] wd, output logic ok, output logic [7:0] rd);
      @(negedge clk_in);
      req_valid_out = 1'b1;
      req_out       = '{dev, adr, is_wr, wd};
      @(posedge clk_in);
      ok = ack_in;
      @(negedge clk_in);
      if (ok !== rsp_valid_in) ok = 1'bx;
      rd            = rdata_in;
      req_valid_out = 1'b0;
      req_out       = mmad_req_s'(~req_out); // released lines lose the old request
   endtask : xfer
endmodule : mmad_host
`default_nettype wire

/* File: verif/tb.sv */
// self-checking testbench for the memory map and address decode block
`timescale 1ns/10ps
`default_nettype none
module tb
   import mmad_pkg::*;
;
   localparam logic [7:0] AUX  = MMAD_AUX_DEV_ADDR;
   localparam logic [7:0] MAIN = MMAD_MAIN_DEV_DFLT;
   logic        core_clk, sys_rst, req_valid, ack, rsp_valid, conv_done, wp_pin;
   mmad_req_s   req;
   logic [7:0]  rdata, res0, res1;
   logic [15:0] conv_value;
   int          err_count, checks;
   // ==========================================================================
   // design and host model
   mmad_decode mmad_decode_i (.core_clk_in(core_clk), .sys_rst_in(sys_rst),
      .req_valid_in(req_valid), .req_in(req), .ack_out(ack), .rsp_valid_out(rsp_valid),
      .rdata_out(rdata), .conv_done_in(conv_done), .conv_value_in(conv_value),
      .write_protect_pin_in(wp_pin), .res0_pos_out(res0), .res1_pos_out(res1));
   mmad_host mmad_host_i (.clk_in(core_clk), .req_valid_out(req_valid), .req_out(req),
      .ack_in(ack), .rsp_valid_in(rsp_valid), .rdata_in(rdata));
   // clock
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // ==========================================================================
   // helpers
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic acc(input logic [7:0] dev, adr, input logic is_wr, input logic [7:0] wd,
                      input logic exp_ok, output logic [7:0] rd);
      logic ok;
      mmad_host_i.xfer(dev, adr, is_wr, wd, ok, rd);
      checks++;
      if (ok !== exp_ok) begin
         err_count++;
         $display("ERROR ack of %h expected %b seen %b", dev, exp_ok, ok);
      end
   endtask : acc
   task automatic wr(input logic [7:0] dev, adr, wd);
      logic [7:0] rd;
      acc(dev, adr, 1'b1, wd, 1'b1, rd);
   endtask : wr
   task automatic rdc(input logic [7:0] dev, adr, exp);
      logic [7:0] rd;
      acc(dev, adr, 1'b0, 8'h00, 1'b1, rd);
      chk($sformatf("byte %h via %h", adr, dev), exp, rd);
   endtask : rdc
   // one conversion result, then a cycle for the positions to land
   task automatic conv(input logic [15:0] v);
      @(negedge core_clk);
      conv_done  = 1'b1;
      conv_value = v;
      @(negedge core_clk);
      conv_done  = 1'b0;
      conv_value = ~v;
      @(negedge core_clk);
   endtask : conv
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up
   // ==========================================================================
   // scenarios
   task automatic t_reset();
      chk("res0 after reset", 8'h00, res0);
      rdc(MAIN, 8'h7F, 8'h00);
      wr(MAIN, 8'h7F, 8'h01);
      rdc(MAIN, 8'h80, 8'h00);
      rdc(MAIN, 8'h8C, 8'hA2);
      wr(MAIN, 8'h40, 8'hA5);
      rdc(MAIN, 8'h40, 8'hA5);
      wr(MAIN, 8'h91, 8'hC3);
      rdc(MAIN, 8'h91, 8'hC3);
      wr(MAIN, 8'h7F, 8'h05);
      wr(MAIN, 8'h91, 8'h3C);
      rdc(MAIN, 8'h91, 8'h00);
      rdc(MAIN, 8'h6A, 8'h00);
      wr(MAIN, 8'h7F, 8'h01);
      rdc(MAIN, 8'h91, 8'hC3);
      $display("reset test done");
   endtask : t_reset
   task automatic t_addr();
      logic [7:0] rd;
      acc(8'hA4, 8'h00, 1'b0, 8'h00, 1'b0, rd);
      acc(AUX, 8'h00, 1'b0, 8'h00, 1'b1, rd);
      wr(MAIN, 8'h8C, 8'hB4);
      wr(MAIN, 8'h80, 8'h04);
      acc(MAIN, 8'h7F, 1'b0, 8'h00, 1'b0, rd);
      rdc(8'hB4, 8'h8C, 8'hB4);
      wr(8'hB4, 8'h80, 8'h06);
      acc(AUX, 8'h00, 1'b0, 8'h00, 1'b0, rd);
      wr(8'hB4, 8'h7F, 8'h00);
      wr(8'hB4, 8'h90, 8'h3C);
      wr(8'hB4, 8'h7F, 8'h01);
      wr(8'hB4, 8'h80, 8'h00);
      rdc(AUX, 8'h10, 8'h3C);
      wr(AUX, 8'h05, 8'h5A);
      rdc(AUX, 8'h85, 8'h00);
      wr(MAIN, 8'h7F, 8'h00);
      rdc(MAIN, 8'h85, 8'h5A);
      wr(MAIN, 8'h7F, 8'h01);
      $display("address test done");
   endtask : t_addr
   task automatic t_protect();
      wr(MAIN, 8'h80, 8'h08);
      wr(MAIN, 8'h82, 8'h77);
      rdc(MAIN, 8'h82, 8'h00);
      wr(MAIN, 8'h40, 8'h5A);
      rdc(MAIN, 8'h40, 8'hA5);
      wp_pin = 1'b0;
      repeat (4) @(negedge core_clk);
      wr(MAIN, 8'h82, 8'h77);
      rdc(MAIN, 8'h82, 8'h77);
      wr(MAIN, 8'h80, 8'h10);
      wr(AUX, 8'h05, 8'hAA);
      rdc(AUX, 8'h05, 8'h5A);
      wr(MAIN, 8'h7F, 8'h00);
      wr(MAIN, 8'h85, 8'hAA);
      rdc(MAIN, 8'h85, 8'h5A);
      wr(MAIN, 8'h7F, 8'h01);
      wr(MAIN, 8'h80, 8'h00);
      wp_pin = 1'b1;
      $display("protect test done");
   endtask : t_protect
   task automatic t_lut();
      logic [7:0]  adrs [4]  = '{8'h80, 8'h81, 8'hC6, 8'hC7};
      logic [15:0] temps [5] = '{16'hCE00, 16'hDA80, 16'h6500, 16'h6600, 16'h7F80};
      int          idx [5]   = '{0, 1, 2, 3, 3};
      wr(MAIN, 8'h83, 8'h99);
      repeat (2) @(negedge core_clk);
      chk("manual res0", 8'h77, res0);
      chk("manual res1", 8'h99, res1);
      for (int t = 2; t < 4; t++) begin
         wr(MAIN, 8'h7F, t[7:0]);
         foreach (adrs[i]) wr(MAIN, adrs[i], {t[3:0], adrs[i][3:0]});
      end
      wr(MAIN, 8'h7F, 8'h01);
      wr(MAIN, 8'h80, 8'h01);
      foreach (temps[k]) begin
         conv(temps[k]);
         chk("lut res0", {4'h2, adrs[idx[k]][3:0]}, res0);
         chk("lut res1", {4'h3, adrs[idx[k]][3:0]}, res1);
         for (int c = 1; c < 5; c++) conv({8'h40 + c[7:0], 8'h0F});
      end
      rdc(MAIN, 8'h60, 8'h7F);
      rdc(MAIN, 8'h61, 8'h80);
      for (int c = 1; c < 5; c++) begin
         rdc(MAIN, 8'h60 + 8'h02 * c[7:0], 8'h40 + c[7:0]);
         rdc(MAIN, 8'h61 + 8'h02 * c[7:0], 8'h0F);
      end
      wr(MAIN, 8'h60, 8'h00);
      rdc(MAIN, 8'h60, 8'h7F);
      wr(MAIN, 8'h80, 8'h00);
      repeat (2) @(negedge core_clk);
      chk("manual res0", 8'h77, res0);
      $display("look-up test done");
   endtask : t_lut
   // ==========================================================================
   // main sequence
   initial begin
      err_count  = 0;
      checks     = 0;
      sys_rst    = 1'b1;
      conv_done  = 1'b0;
      conv_value = 16'h0000;
      wp_pin     = 1'b1;
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      sys_rst = 1'b0;
      t_reset();
      t_addr();
      t_protect();
      t_lut();
      wrap_up();
   end
   // watchdog: the sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge core_clk);
      err_count++;
      wrap_up();
   end
endmodule : tb
`default_nettype wire
